// >>> logic/tscfg_consts.svh
/*
 * Constants of the thermal sensor capability and configuration registers:
 * pointer values, field positions, fixed contents and reset values.
 * Assumes inclusion by the register module only.
 */
`ifndef TSCFG_CONSTS_SVH
`define TSCFG_CONSTS_SVH

// ----------------------------------------------------------------------
// Pointer locations
// ----------------------------------------------------------------------
`define TSCFG_PTR_CAP        8'h00
`define TSCFG_PTR_CFG        8'h01
`define TSCFG_PTR_RESET      8'h00

// ----------------------------------------------------------------------
// Capability register fields and fixed value
// ----------------------------------------------------------------------
`define TSCFG_CAP_RSVD_MSB   15
`define TSCFG_CAP_RSVD_LSB   6
`define TSCFG_CAP_HV_BIT     5
`define TSCFG_CAP_RES_MSB    4
`define TSCFG_CAP_RES_LSB    3
`define TSCFG_CAP_RES_VAL    2'h2
`define TSCFG_CAP_WIDE_BIT   2
`define TSCFG_CAP_ACC_BIT    1
`define TSCFG_CAP_ALARM_BIT  0
`define TSCFG_CAP_VALUE      16'h0037

// ----------------------------------------------------------------------
// Configuration register fields and reset value
// ----------------------------------------------------------------------
`define TSCFG_CFG_RSVD_MSB   15
`define TSCFG_CFG_RSVD_LSB   11
`define TSCFG_CFG_HYST_MSB   10
`define TSCFG_CFG_HYST_LSB   9
`define TSCFG_CFG_SHDN_BIT   8
`define TSCFG_CFG_CLOCK_BIT  7
`define TSCFG_CFG_WLOCK_BIT  6
`define TSCFG_CFG_WR_MASK    16'h07FF
`define TSCFG_CFG_RESET      16'h0000
`define TSCFG_RD_UNMAPPED    16'h0000

`endif

// >>> logic/tscfg_pkg.sv
/*
 * Types of the thermal sensor capability and configuration registers.
 * Assumes the constants header is on the include path.
 */
package tscfg_pkg;

    // ------------------------------------------------------------------
    // Configuration register layout
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        TSCFG_HYST_OFF,
        TSCFG_HYST_1P5C,
        TSCFG_HYST_3C,
        TSCFG_HYST_6C
    } tscfg_hyst_t;

    typedef struct packed {
        logic [4:0]  reserved_field;
        tscfg_hyst_t hysteresis_select;
        logic        shutdown_bit;
        logic        critical_lock;
        logic        window_lock;
        logic        clear_event;
        logic        event_status;
        logic        event_output_enable;
        logic        critical_only_select;
        logic        event_polarity;
        logic        event_mode;
    } tscfg_cfg_t;

    // ------------------------------------------------------------------
    // Byte stream from the serial engine
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       valid;
        logic       is_pointer;
        logic [7:0] data;
    } tscfg_byte_t;

    typedef enum logic {
        TSCFG_WAIT_MSB,
        TSCFG_WAIT_LSB
    } tscfg_pair_t;

endpackage

// >>> logic/tscfg_regs.sv
/*
 * Capability and configuration registers of a temperature sensor,
 * reached through an 8-bit pointer from the serial protocol engine.
 * Assumes the engine delivers received bytes as one-cycle strobes
 * synchronous to SYS_CLK_I, flags the pointer byte, and pulses
 * FRAME_START_I at every start condition.
 */
// Functional notes
// - Capability at pointer 00h, fixed, read-only
// - Capability bits 15:6 read zero
// - Capability bit 5 reads one
// - Capability resolution field reads binary 10
// - Capability bit 2 reads one
// - Capability bit 1 reads one
// - Capability bit 0 reads one
// - Configuration at pointer 01h, read/write, resets zero
// - Configuration bits 15:11 read-only zero
// - Configuration fields laid out as documented
// - Hysteresis codes off, 1.5, 3, 6 degrees
// - Locks freeze protected bits until released
// - Read-only writes acknowledged, contents unchanged
`include "tscfg_consts.svh"

module tscfg_regs
    import tscfg_pkg::*;
(
    // Clock and reset
    input  wire logic        SYS_CLK_I,
    input  wire logic        NRST_I,
    // Byte stream from the serial engine
    input  wire logic        FRAME_START_I,
    input  wire tscfg_byte_t BYTE_I,
    // Answers to the serial engine
    output logic             ACK_O,
    output logic [7:0]       PTR_O,
    output logic [15:0]      RD_DATA_O,
    // Configuration to the sensor core
    output tscfg_cfg_t       CFG_O
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [7:0]  ptr_q;
    logic [7:0]  msb_q;
    tscfg_pair_t pair_q;
    tscfg_cfg_t  cfg_q;
    tscfg_cfg_t  cfg_d;
    logic [15:0] wdata;
    logic        data_byte;
    logic        commit;
    logic        lock_any;
    logic [15:0] rd_d;

    assign data_byte = BYTE_I.valid && !BYTE_I.is_pointer;
    assign commit    = data_byte && (pair_q == TSCFG_WAIT_LSB);
    assign wdata     = {msb_q, BYTE_I.data};
    assign lock_any  = cfg_q.critical_lock || cfg_q.window_lock;

    // ------------------------------------------------------------------
    // Pointer
    // ------------------------------------------------------------------
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            ptr_q <= `TSCFG_PTR_RESET;
        end else if (BYTE_I.valid && BYTE_I.is_pointer) begin
            ptr_q <= BYTE_I.data;
        end
    end

    // ------------------------------------------------------------------
    // Byte pairing, most significant byte first
    // ------------------------------------------------------------------
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            pair_q <= TSCFG_WAIT_MSB;
            msb_q  <= 8'h00;
        end else if (FRAME_START_I || (BYTE_I.valid && BYTE_I.is_pointer)) begin
            pair_q <= TSCFG_WAIT_MSB;
        end else if (data_byte) begin
            case (pair_q)
                TSCFG_WAIT_MSB: begin
                    msb_q  <= BYTE_I.data;
                    pair_q <= TSCFG_WAIT_LSB;
                end
                TSCFG_WAIT_LSB: begin
                    pair_q <= TSCFG_WAIT_MSB;
                end
                default: begin
                    pair_q <= TSCFG_WAIT_MSB;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Configuration register
    // ------------------------------------------------------------------
    always_comb begin
        cfg_d = tscfg_cfg_t'(wdata & `TSCFG_CFG_WR_MASK);
        cfg_d.reserved_field = 5'h00;
        if (lock_any) begin
            cfg_d.hysteresis_select = cfg_q.hysteresis_select;
            cfg_d.shutdown_bit      = cfg_q.shutdown_bit;
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            cfg_q <= tscfg_cfg_t'(`TSCFG_CFG_RESET);
        end else if (commit && (ptr_q == `TSCFG_PTR_CFG)) begin
            cfg_q <= cfg_d;
        end
    end

    // ------------------------------------------------------------------
    // Acknowledge: every received byte, whatever its target
    // ------------------------------------------------------------------
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            ACK_O <= 1'b0;
        end else begin
            ACK_O <= BYTE_I.valid;
        end
    end

    // ------------------------------------------------------------------
    // Read data for the pointed register
    // ------------------------------------------------------------------
    always_comb begin
        case (ptr_q)
            `TSCFG_PTR_CAP: rd_d = `TSCFG_CAP_VALUE;
            `TSCFG_PTR_CFG: rd_d = cfg_q;
            default:        rd_d = `TSCFG_RD_UNMAPPED;
        endcase
    end

    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            RD_DATA_O <= `TSCFG_CAP_VALUE;
            PTR_O     <= `TSCFG_PTR_RESET;
            CFG_O     <= tscfg_cfg_t'(`TSCFG_CFG_RESET);
        end else begin
            RD_DATA_O <= rd_d;
            PTR_O     <= ptr_q;
            CFG_O     <= cfg_q;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!NRST_I);

    property p_cap_fixed;
        ptr_q == `TSCFG_PTR_CAP |=> RD_DATA_O == 16'h0037;
    endproperty
    a_cap_fixed: assert property (p_cap_fixed)
        else $error("capability value wrong");

    property p_cap_rsvd;
        ptr_q == `TSCFG_PTR_CAP |=> RD_DATA_O[15:6] == 10'h000;
    endproperty
    a_cap_rsvd: assert property (p_cap_rsvd)
        else $error("capability reserved bits not zero");

    property p_cap_hv;
        ptr_q == `TSCFG_PTR_CAP |=> RD_DATA_O[`TSCFG_CAP_HV_BIT];
    endproperty
    a_cap_hv: assert property (p_cap_hv)
        else $error("high voltage flag not set");

    property p_cap_res;
        ptr_q == `TSCFG_PTR_CAP |=> RD_DATA_O[4:3] == 2'h2;
    endproperty
    a_cap_res: assert property (p_cap_res)
        else $error("resolution field wrong");

    property p_cap_flags;
        ptr_q == `TSCFG_PTR_CAP |=> RD_DATA_O[2:0] == 3'h7;
    endproperty
    a_cap_flags: assert property (p_cap_flags)
        else $error("range, accuracy or alarm flag not set");

    property p_cfg_readback;
        commit && ptr_q == `TSCFG_PTR_CFG && !lock_any
            |=> ##1 RD_DATA_O == ($past(wdata, 2) & 16'h07FF);
    endproperty
    a_cfg_readback: assert property (p_cfg_readback)
        else $error("configuration write not read back");

    property p_cfg_rsvd;
        ptr_q == `TSCFG_PTR_CFG |=> RD_DATA_O[15:11] == 5'h00;
    endproperty
    a_cfg_rsvd: assert property (p_cfg_rsvd)
        else $error("configuration reserved bits not zero");

    property p_cfg_low;
        commit && ptr_q == `TSCFG_PTR_CFG |=> cfg_q[7:0] == $past(BYTE_I.data);
    endproperty
    a_cfg_low: assert property (p_cfg_low)
        else $error("configuration low byte not stored");

    property p_lock_hold;
        lock_any |=> $stable(cfg_q.hysteresis_select) && $stable(cfg_q.shutdown_bit);
    endproperty
    a_lock_hold: assert property (p_lock_hold)
        else $error("locked bits changed");

    property p_ro_write;
        commit && ptr_q == `TSCFG_PTR_CAP |=> ACK_O ##1 RD_DATA_O == 16'h0037;
    endproperty
    a_ro_write: assert property (p_ro_write)
        else $error("read-only write not acknowledged or took effect");

    property p_ack;
        BYTE_I.valid |=> ACK_O;
    endproperty
    a_ack: assert property (p_ack)
        else $error("byte not acknowledged");

    property p_pair;
        data_byte && pair_q == TSCFG_WAIT_MSB && !FRAME_START_I
            |=> pair_q == TSCFG_WAIT_LSB && msb_q == $past(BYTE_I.data);
    endproperty
    a_pair: assert property (p_pair)
        else $error("first data byte not held as MSB");

    property p_ack_idle;
        !BYTE_I.valid |=> !ACK_O;
    endproperty
    a_ack_idle: assert property (p_ack_idle)
        else $error("acknowledge without a received byte");

    property p_ptr_load;
        BYTE_I.valid && BYTE_I.is_pointer |=> ptr_q == $past(BYTE_I.data);
    endproperty
    a_ptr_load: assert property (p_ptr_load)
        else $error("pointer byte not latched");

    property p_cfg_hold;
        !(commit && ptr_q == `TSCFG_PTR_CFG) |=> $stable(cfg_q);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold)
        else $error("configuration changed without a write to it");

    property p_cfg_rsvd_q;
        cfg_q.reserved_field == 5'h00;
    endproperty
    a_cfg_rsvd_q: assert property (p_cfg_rsvd_q)
        else $error("reserved configuration bits stored");

    property p_unmapped;
        ptr_q > `TSCFG_PTR_CFG |=> RD_DATA_O == `TSCFG_RD_UNMAPPED;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped pointer does not read zero");

    property p_lock_low;
        commit && ptr_q == `TSCFG_PTR_CFG && lock_any
            |=> cfg_q[7:0] == $past(BYTE_I.data) && cfg_q[10:8] == $past(cfg_q[10:8]);
    endproperty
    a_lock_low: assert property (p_lock_low)
        else $error("locked write handled wrongly");

    property p_hyst_store;
        commit && ptr_q == `TSCFG_PTR_CFG && !lock_any
            |=> cfg_q.hysteresis_select == $past(msb_q[2:1]);
    endproperty
    a_hyst_store: assert property (p_hyst_store)
        else $error("hysteresis code not stored");

    property p_shdn_store;
        commit && ptr_q == `TSCFG_PTR_CFG && !lock_any
            |=> cfg_q.shutdown_bit == $past(msb_q[0]);
    endproperty
    a_shdn_store: assert property (p_shdn_store)
        else $error("shutdown bit not stored");

    property p_locks_store;
        commit && ptr_q == `TSCFG_PTR_CFG
            |=> {cfg_q.critical_lock, cfg_q.window_lock} == $past(BYTE_I.data[7:6]);
    endproperty
    a_locks_store: assert property (p_locks_store)
        else $error("lock bits not stored");

    property p_frame_drop;
        FRAME_START_I |=> pair_q == TSCFG_WAIT_MSB;
    endproperty
    a_frame_drop: assert property (p_frame_drop)
        else $error("held high byte kept across a start");

    property p_ptr_drop;
        BYTE_I.valid && BYTE_I.is_pointer |=> pair_q == TSCFG_WAIT_MSB;
    endproperty
    a_ptr_drop: assert property (p_ptr_drop)
        else $error("held high byte kept across a pointer byte");

    property p_commit_pair;
        commit |=> pair_q == TSCFG_WAIT_MSB;
    endproperty
    a_commit_pair: assert property (p_commit_pair)
        else $error("pair not restarted after low byte");

    c_cfg_write: cover property (commit && ptr_q == `TSCFG_PTR_CFG && !lock_any);
    c_locked_write: cover property (commit && ptr_q == `TSCFG_PTR_CFG && lock_any);
    c_cap_write: cover property (commit && ptr_q == `TSCFG_PTR_CAP);
    c_unmapped: cover property (ptr_q > `TSCFG_PTR_CFG);

endmodule

// >>> dv/tscfg_host.sv
/*
 * Host model: a serial engine front end that hands the register block
 * framed pointer and data bytes, and reads the pointed register back.
 * Assumes the block answers each byte with a one-cycle acknowledge.
 */
module tscfg_host
    import tscfg_pkg::*;
(
    // Clock and answers
    input  wire logic        clk_i,
    input  wire logic        ack_i,
    input  wire logic [15:0] rd_data_i,
    // Byte stream
    output logic             frame_start_o,
    output tscfg_byte_t      byte_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        frame_start_o = 1'b0;
        byte_o = '0;
    end

    // ------------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------------
    task automatic frame();
        @(negedge clk_i);
        frame_start_o = 1'b1;
        @(negedge clk_i);
        frame_start_o = 1'b0;
    endtask

    // Released lines show the inverse of the last byte
    task automatic send(input logic is_ptr, input logic [7:0] data, output logic acked);
        @(negedge clk_i);
        byte_o = '{valid: 1'b1, is_pointer: is_ptr, data: data};
        @(negedge clk_i);
        byte_o = '{valid: 1'b0, is_pointer: ~is_ptr, data: ~data};
        acked = ack_i;
        @(negedge clk_i);
        acked = acked | ack_i;
    endtask

    // Pointer first, then the two data bytes high byte first
    task automatic write_reg(input logic [7:0] ptr, input logic [15:0] val, output logic ok);
        logic a0;
        logic a1;
        logic a2;
        frame();
        send(1'b1, ptr, a0);
        send(1'b0, val[15:8], a1);
        send(1'b0, val[7:0], a2);
        ok = a0 & a1 & a2;
    endtask

    task automatic read_reg(input logic [7:0] ptr, output logic [15:0] val);
        logic a;
        frame();
        send(1'b1, ptr, a);
        val = rd_data_i;
    endtask
endmodule

// >>> dv/tb.sv
/*
 * Testbench of the capability and configuration registers.
 * Assumes the host model drives the byte stream on falling edges.
 */
module tb
    import tscfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        sys_clk;
    logic        nrst;
    logic        frame_start;
    tscfg_byte_t byte_s;
    logic        ack;
    logic [7:0]  ptr;
    logic [15:0] rd_data;
    tscfg_cfg_t  cfg;
    int          miscompares = 0;
    int          total_checks = 0;

    tscfg_regs i_tscfg_regs (
        .SYS_CLK_I    (sys_clk),
        .NRST_I       (nrst),
        .FRAME_START_I(frame_start),
        .BYTE_I       (byte_s),
        .ACK_O        (ack),
        .PTR_O        (ptr),
        .RD_DATA_O    (rd_data),
        .CFG_O        (cfg)
    );

    tscfg_host i_tscfg_host (
        .clk_i        (sys_clk),
        .ack_i        (ack),
        .rd_data_i    (rd_data),
        .frame_start_o(frame_start),
        .byte_o       (byte_s)
    );

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] p, input logic [15:0] v);
        logic ok;
        i_tscfg_host.write_reg(p, v, ok);
        check({15'h0000, ok}, 16'h0001);
    endtask

    task automatic rd(input logic [7:0] p, input logic [15:0] exp);
        logic [15:0] v;
        i_tscfg_host.read_reg(p, v);
        check(v, exp);
    endtask

    task automatic summarize();
        if (miscompares == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Clock and watchdog
    // ------------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    initial begin
        #100000;
        miscompares++;
        summarize();
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        nrst = 1'b0;
        repeat (2) @(negedge sys_clk);
        check(rd_data, 16'h0037);
        check(cfg, 16'h0000);
        check({8'h00, ptr}, 16'h0000);
        check({15'h0000, ack}, 16'h0000);
        nrst = 1'b1;
        wr(8'h00, 16'hFFFF);
        rd(8'h00, 16'h0037);
        wr(8'h01, 16'h0209);
        rd(8'h01, 16'h0209);
        check({8'h00, ptr}, 16'h0001);
        // Descending so that a lock bit only guards bits already zero
        for (int b = 10; b >= 0; b--) begin
            wr(8'h01, 16'h0001 << b);
            rd(8'h01, 16'h0001 << b);
            check(cfg, 16'h0001 << b);
        end
        for (int h = 0; h < 4; h++) begin
            wr(8'h01, 16'(h) << 9);
            check({14'h0000, cfg.hysteresis_select}, 16'(h));
        end
        wr(8'h01, 16'hFFFF);
        rd(8'h01, 16'h07FF);
        wr(8'h01, 16'h0000);
        rd(8'h01, 16'h0700);
        wr(8'h01, 16'h0000);
        wr(8'h01, 16'h0140);
        wr(8'h01, 16'h0000);
        check(cfg, 16'h0100);
        wr(8'h01, 16'h0000);
        check(cfg, 16'h0000);
        // Lone high byte must be dropped by the next start, pointer unchanged
        begin
            logic a;
            i_tscfg_host.frame();
            i_tscfg_host.send(1'b1, 8'h01, a);
            i_tscfg_host.send(1'b0, 8'hAA, a);
            i_tscfg_host.frame();
            i_tscfg_host.send(1'b0, 8'h00, a);
            i_tscfg_host.send(1'b0, 8'h03, a);
            check({15'h0000, a}, 16'h0001);
        end
        rd(8'h01, 16'h0003);
        wr(8'h01, 16'h0005);
        rd(8'h01, 16'h0005);
        rd(8'h05, 16'h0000);
        @(negedge sys_clk);
        nrst = 1'b0;
        @(negedge sys_clk);
        check(cfg, 16'h0000);
        check(rd_data, 16'h0037);
        check({8'h00, ptr}, 16'h0000);
        nrst = 1'b1;
        rd(8'h01, 16'h0000);
        summarize();
    end
endmodule
